// ### shared/usart_cfg.svh
`ifndef USART_CFG_SVH
`define USART_CFG_SVH

// host port select values
`define SEL_DATA        1'b0
`define SEL_CTRL        1'b1

// mode byte fields
`define MODE_SYNC_LO    0
`define MODE_LEN_LO     2
`define MODE_PAR_EN     4
`define MODE_PAR_EVEN   5
`define MODE_EXT_SYNC   6
`define MODE_ONE_SYNC   7
`define SYNC_MODE_CODE  2'h0
`define MODE_RESET      8'h00

// command byte fields
`define CMD_TX_EN       0
`define CMD_TERM_RDY    1
`define CMD_RX_EN       2
`define CMD_ERR_CLR     4
`define CMD_RTS         5
`define CMD_SOFT_RST    6
`define CMD_HUNT        7
`define CMD_RESET       8'h00

// status byte fields
`define STAT_TX_FREE    0
`define STAT_RX_AVAIL   1
`define STAT_TX_EMPTY   2
`define STAT_PAR_ERR    3
`define STAT_OVR_ERR    4
`define STAT_FRM_ERR    5
`define STAT_MATCH      6

// receive window holds two frames of up to nine bits
`define BUF_W           18
`define MIN_CHAR_LEN    4'h5
// rx clock rises seen while the sync input stays high
`define EXT_SYNC_EDGES  2'h2

`endif

// ### shared/usart_pkg.sv
`default_nettype none
`include "usart_cfg.svh"

package usart_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [1:0] {PH_STANDBY, PH_SYNC1, PH_SYNC2, PH_COMMAND} phase_e;

    typedef struct packed {
        phase_e              phase;
        byte_t               mode;
        byte_t               sync1;
        byte_t               sync2;
        byte_t               cmd;
        logic [`BUF_W-1:0]   rxBuf;
        logic                hunting;
        logic [3:0]          rxBitCnt;
        byte_t               serial_in;
        logic                rxAvail;
        logic                parityErr;
        logic                overrunErr;
        logic                frameErr;
        logic                matchFlag;
        logic                extArmed;
        logic [1:0]          extCnt;
        logic                txStarted;
        byte_t               txHold;
        logic                txHoldFull;
        logic [7:0]          txShift;
        logic [3:0]          txLeft;
        logic                txNextSync2;
        logic                txEmpty;
        logic                serialOut;
        logic                txBufferFree;
        logic                matchOrBreakOut;
        logic                terminalReadyOutN;
        logic                requestToSendOutN;
        byte_t               rdData;
    } usart_s;

endpackage

`default_nettype wire

// ### hw/level_sync.sv
`timescale 1ns/1ns
`default_nettype none

module level_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic         clockEnable,
    // levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } sync_s;

    sync_s s_r;
    sync_s s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.stage1 = din;
        s_nxt.stage2 = s_r.stage1;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            s_r <= '0;
        else if (clockEnable)
            s_r <= s_nxt;
    end

    assign dout = s_r.stage2;

endmodule

`default_nettype wire

// ### hw/edge_find.sv
`timescale 1ns/1ns
`default_nettype none

module edge_find #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic         clockEnable,
    // synchronised levels in, one-cycle edge pulses out
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    typedef struct packed {
        logic [W-1:0] prev;
    } edge_s;

    edge_s s_r;
    edge_s s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.prev = level;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            s_r <= '0;
        else if (clockEnable)
            s_r <= s_nxt;
    end

    // masking pulses off while the enable is low keeps edges from being counted twice
    assign rise = level & ~s_r.prev & {W{clockEnable}};
    assign fall = ~level & s_r.prev & {W{clockEnable}};

endmodule

`default_nettype wire

// ### hw/usart_sync_hunt_standby.sv
// Overview of operation
// - sync fill starts only after data written
// - hunt entry presets receive buffer ones
// - shift and compare on rx clock rise
// - internal match ends hunt, sets match
// - assembly starts at the following bit
// - external sync ends hunt, flags status
// - each long sync pulse sets status
// - hunt command accepted at any time
// - received sync characters set match flag
// - errors only flag; no parity in hunt
// - standby ignores all clock edges
// - hardware reset enters standby
// - software reset command enters standby
// - only a mode byte leaves standby
// - standby pins held at fixed levels
// - fill sync when empty, data clears
// - one bit per tx clock fall
// - hunt ignored outside synchronous mode
// - error clear zeroes all error flags
`timescale 1ns/1ns
`default_nettype none
`include "usart_cfg.svh"

module usart_sync_hunt_standby (
    // clock and reset
    input  wire logic           clock,
    input  wire logic           nrst,
    input  wire logic           clockEnable,
    // host port
    input  wire logic           controlSelect,
    input  wire usart_pkg::byte_t wrData,
    input  wire logic           wrStb,
    input  wire logic           rdStb,
    output logic [7:0]          rdData,
    // serial link
    input  wire logic           txBitClock,
    input  wire logic           rxBitClock,
    input  wire logic           serialIn,
    input  wire logic           syncIn,
    input  wire logic           clearToSendN,
    output logic                serialOut,
    // status and modem pins
    output logic                txBufferFree,
    output logic                txEmptyFlag,
    output logic                rxCharAvail,
    output logic                matchOrBreakOut,
    output logic                terminalReadyOutN,
    output logic                requestToSendOutN
);
    import usart_pkg::*;

    localparam logic [4:0] BufTop = 5'(`BUF_W);

    usart_s s;
    usart_s n;

    logic [4:0] pinSync;
    logic [2:0] edgeRise;
    logic [2:0] edgeFall;
    logic       ctrlWr;
    logic       dataWr;
    logic       statRd;
    logic       dataRd;
    logic       charDone;
    logic       intMatch;
    logic       extDone;
    logic       syncMode;
    logic       parEn;
    logic [3:0] charLen;
    logic [3:0] frameLen;
    logic [4:0] newSh;
    logic [4:0] oldSh;
    byte_t      newChar;
    byte_t      oldChar;
    byte_t      sync1M;
    byte_t      sync2M;
    byte_t      txChar;
    logic [8:0] txFrame;

    // order: tx_bit_clock, rx_bit_clock, serialIn, syncIn, ctsN; data rides the same delay as its clock
    level_sync #(.W(5)) pinSyncU (
        .clock       (clock),
        .nrst        (nrst),
        .clockEnable (clockEnable),
        .din         ({clearToSendN, syncIn, serialIn, rxBitClock, txBitClock}),
        .dout        (pinSync)
    );

    edge_find #(.W(3)) edgeU (
        .clock       (clock),
        .nrst        (nrst),
        .clockEnable (clockEnable),
        .level       ({pinSync[3], pinSync[1], pinSync[0]}),
        .rise        (edgeRise),
        .fall        (edgeFall)
    );

    function automatic byte_t frameData(input logic [`BUF_W-1:0] b, input logic [4:0] sh,
                                        input logic [3:0] len);
        logic [`BUF_W-1:0] t;
        byte_t             mask;
        t = b >> sh;
        mask = 8'hFF >> (4'h8 - len);
        return t[7:0] & mask;
    endfunction

    always_comb
    begin
        n = s;
        ctrlWr = wrStb && (controlSelect == `SEL_CTRL);
        dataWr = wrStb && (controlSelect == `SEL_DATA);
        statRd = rdStb && (controlSelect == `SEL_CTRL);
        dataRd = rdStb && (controlSelect == `SEL_DATA);
        syncMode = s.mode[`MODE_SYNC_LO +: 2] == `SYNC_MODE_CODE;
        parEn = s.mode[`MODE_PAR_EN];
        charLen = `MIN_CHAR_LEN + {2'h0, s.mode[`MODE_LEN_LO +: 2]};
        frameLen = charLen + {3'h0, parEn};
        newSh = BufTop - {1'h0, frameLen};
        oldSh = newSh - {1'h0, frameLen};
        sync1M = frameData({10'h000, s.sync1}, 5'h00, charLen);
        sync2M = frameData({10'h000, s.sync2}, 5'h00, charLen);
        charDone = 1'b0;
        intMatch = 1'b0;
        extDone = 1'b0;
        newChar = 8'h00;
        oldChar = 8'h00;
        txChar = 8'h00;
        txFrame = 9'h000;
        n.rdData = 8'h00;

        if (s.phase == PH_STANDBY)
        begin
            // edges are not looked at here at all
            if (ctrlWr)
            begin
                n.mode = wrData;
                n.phase = (wrData[`MODE_SYNC_LO +: 2] == `SYNC_MODE_CODE) ? PH_SYNC1
                                                                           : PH_COMMAND;
            end
            // a data write here is dropped
        end
        else
        begin
            if (statRd)
            begin
                n.rdData = {1'b0, s.matchFlag, s.frameErr, s.overrunErr, s.parityErr,
                            s.txEmpty, s.rxAvail, !s.txHoldFull};
                n.matchFlag = 1'b0;
            end
            if (dataRd)
            begin
                n.rdData = s.serial_in;
                n.rxAvail = 1'b0;
            end
            // clear first so that a same-cycle error still lands
            if (ctrlWr && s.phase == PH_COMMAND && wrData[`CMD_ERR_CLR])
            begin
                n.parityErr = 1'b0;
                n.overrunErr = 1'b0;
                n.frameErr = 1'b0;
            end
            if (dataWr)
            begin
                n.txHold = wrData;
                n.txHoldFull = 1'b1;
                n.txStarted = 1'b1;
                n.txEmpty = 1'b0;
            end

            // receiver
            if (edgeRise[1] && s.cmd[`CMD_RX_EN])
            begin
                n.rxBuf = {pinSync[2], s.rxBuf[`BUF_W-1:1]};
                newChar = frameData(n.rxBuf, newSh, charLen);
                oldChar = frameData(n.rxBuf, oldSh, charLen);
                if (s.hunting)
                begin
                    if (!s.mode[`MODE_EXT_SYNC])
                    begin
                        // compare on every shift
                        if (s.mode[`MODE_ONE_SYNC])
                            intMatch = newChar == sync1M;
                        else
                            intMatch = (oldChar == sync1M) && (newChar == sync2M);
                        if (intMatch)
                        begin
                            n.hunting = 1'b0;
                            n.matchFlag = 1'b1;
                            n.rxBitCnt = 4'h0;
                        end
                    end
                end
                else if (s.rxBitCnt == frameLen - 4'h1)
                begin
                    charDone = 1'b1;
                    n.rxBitCnt = 4'h0;
                    n.serial_in = newChar;
                    n.overrunErr = n.overrunErr | n.rxAvail;
                    n.rxAvail = 1'b1;
                    if (parEn && (^newChar ^ n.rxBuf[`BUF_W-1] ^ !s.mode[`MODE_PAR_EVEN]))
                        n.parityErr = 1'b1;
                    if (newChar == sync1M || (!s.mode[`MODE_ONE_SYNC] && newChar == sync2M))
                        n.matchFlag = 1'b1;
                end
                else
                begin
                    n.rxBitCnt = s.rxBitCnt + 4'h1;
                end
            end

            // external sync: a rise, then high across a whole rx clock period
            if (s.mode[`MODE_EXT_SYNC])
            begin
                if (edgeRise[2])
                begin
                    n.extArmed = 1'b1;
                    n.extCnt = 2'h0;
                end
                else if (!pinSync[3])
                begin
                    n.extArmed = 1'b0;
                end
                else if (s.extArmed && edgeRise[1])
                begin
                    n.extCnt = s.extCnt + 2'h1;
                    if (n.extCnt == `EXT_SYNC_EDGES)
                    begin
                        extDone = 1'b1;
                        n.extArmed = 1'b0;
                        n.matchFlag = 1'b1;
                        if (s.hunting)
                        begin
                            n.hunting = 1'b0;
                            n.rxBitCnt = 4'h0;
                        end
                    end
                end
            end

            // transmitter: one bit per falling edge while clear to send
            if (edgeFall[0] && s.cmd[`CMD_TX_EN] && !pinSync[4])
            begin
                if (s.txLeft == 4'h0)
                begin
                    if (n.txHoldFull)
                    begin
                        txChar = n.txHold;
                        n.txHoldFull = 1'b0;
                        n.txNextSync2 = 1'b0;
                    end
                    else if (n.txStarted)
                    begin
                        // host fell behind: fill with sync characters
                        txChar = s.txNextSync2 ? s.sync2 : s.sync1;
                        n.txEmpty = 1'b1;
                        n.txNextSync2 = !s.mode[`MODE_ONE_SYNC] && !s.txNextSync2;
                    end
                    if (n.txStarted)
                    begin
                        txChar = frameData({10'h000, txChar}, 5'h00, charLen);
                        txFrame = {1'b0, txChar};
                        if (parEn)
                            txFrame[charLen] = ^txChar ^ !s.mode[`MODE_PAR_EVEN];
                        n.serialOut = txFrame[0];
                        n.txShift = txFrame[8:1];
                        n.txLeft = frameLen - 4'h1;
                    end
                end
                else
                begin
                    n.serialOut = s.txShift[0];
                    n.txShift = {1'b0, s.txShift[7:1]};
                    n.txLeft = s.txLeft - 4'h1;
                end
            end

            // command and sync character writes
            if (ctrlWr)
            begin
                case (s.phase)
                    PH_SYNC1:
                    begin
                        n.sync1 = wrData;
                        n.phase = s.mode[`MODE_ONE_SYNC] ? PH_COMMAND : PH_SYNC2;
                    end
                    PH_SYNC2:
                    begin
                        n.sync2 = wrData;
                        n.phase = PH_COMMAND;
                    end
                    default:
                    begin
                        n.cmd = wrData;
                        // hunt may be re-entered at any time
                        if (wrData[`CMD_HUNT] && syncMode)
                        begin
                            n.hunting = 1'b1;
                            n.rxBuf = '1;
                            n.rxBitCnt = 4'h0;
                            n.extArmed = 1'b0;
                        end
                        if (wrData[`CMD_SOFT_RST])
                            n.phase = PH_STANDBY;
                    end
                endcase
            end
        end

        if (n.phase == PH_STANDBY)
        begin
            n.cmd = `CMD_RESET;
            n.hunting = 1'b0;
            n.rxAvail = 1'b0;
            n.matchFlag = 1'b0;
            n.extArmed = 1'b0;
            n.txStarted = 1'b0;
            n.txHoldFull = 1'b0;
            n.txLeft = 4'h0;
            n.txNextSync2 = 1'b0;
            n.txEmpty = 1'b0;
            n.serialOut = 1'b1;
        end
        // pins derived from next state so they move with it
        n.txBufferFree = n.phase != PH_STANDBY && !n.txHoldFull && !pinSync[4]
                         && n.cmd[`CMD_TX_EN];
        n.matchOrBreakOut = n.phase != PH_STANDBY && n.matchFlag;
        n.terminalReadyOutN = !n.cmd[`CMD_TERM_RDY];
        n.requestToSendOutN = !n.cmd[`CMD_RTS];
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s <= '0;
            s.phase <= PH_STANDBY;
            s.mode <= `MODE_RESET;
            s.rxBuf <= '1;
            s.serialOut <= 1'b1;
            s.terminalReadyOutN <= 1'b1;
            s.requestToSendOutN <= 1'b1;
        end
        else if (clockEnable)
        begin
            s <= n;
        end
    end

    assign rdData = s.rdData;
    assign serialOut = s.serialOut;
    assign txBufferFree = s.txBufferFree;
    assign txEmptyFlag = s.txEmpty;
    assign rxCharAvail = s.rxAvail;
    assign matchOrBreakOut = s.matchOrBreakOut;
    assign terminalReadyOutN = s.terminalReadyOutN;
    assign requestToSendOutN = s.requestToSendOutN;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    sequence huntCmd_s;
        clockEnable && ctrlWr && s.phase == PH_COMMAND && wrData[`CMD_HUNT]
            && !wrData[`CMD_SOFT_RST];
    endsequence

    sequence intMatch_s;
        clockEnable && intMatch && !ctrlWr;
    endsequence

    sequence extDone_s;
        clockEnable && extDone && !ctrlWr;
    endsequence

    hunt_preset_a: assert property (huntCmd_s ##0 syncMode |=> s.hunting && (&s.rxBuf))
        else $error("hunt command did not preset the receive buffer");
    hunt_ignored_a: assert property (huntCmd_s ##0 (!syncMode && !s.hunting) |=> !s.hunting)
        else $error("hunt entered outside synchronous mode");
    internal_match_a: assert property (intMatch_s |=> s.matchFlag && !s.hunting
                                                   && s.rxBitCnt == 4'h0)
        else $error("internal match did not end hunt");
    external_sync_a: assert property (extDone_s |=> s.matchFlag && !s.hunting)
        else $error("external sync did not flag status");
    standby_pins_a: assert property (s.phase == PH_STANDBY |-> !txBufferFree && !txEmptyFlag
                                    && !rxCharAvail && !matchOrBreakOut && serialOut
                                    && terminalReadyOutN && requestToSendOutN)
        else $error("standby pin levels wrong");
    soft_reset_a: assert property (clockEnable && ctrlWr && s.phase == PH_COMMAND
                                   && wrData[`CMD_SOFT_RST] |=> s.phase == PH_STANDBY)
        else $error("software reset did not enter standby");
    stay_standby_a: assert property (s.phase == PH_STANDBY && !(clockEnable && ctrlWr)
                                     |=> s.phase == PH_STANDBY)
        else $error("standby left without a mode byte");
    idle_mark_a: assert property (s.phase != PH_STANDBY && !s.txStarted |-> serialOut)
        else $error("line left mark before any data was written");
    empty_clear_a: assert property (clockEnable && dataWr && s.phase != PH_STANDBY
                                    |=> !txEmptyFlag && s.txStarted)
        else $error("data write did not clear the empty flag");
    error_clear_a: assert property (clockEnable && ctrlWr && s.phase == PH_COMMAND
                                    && wrData[`CMD_ERR_CLR] && !charDone
                                    |=> !s.parityErr && !s.overrunErr && !s.frameErr)
        else $error("error clear left a flag set");
    hunt_parity_a: assert property (s.hunting |=> !$rose(s.parityErr))
        else $error("parity checked during hunt");

endmodule

`default_nettype wire

// ### testbench/remote_station.sv
`timescale 1ns/1ns
`default_nettype none

module remote_station (
    // link toward the block
    output logic      rxBitClock,
    output logic      serialIn,
    output logic      syncIn,
    output logic      txBitClock,
    input  wire logic serialOut
);
    bit txSeen[$];

    initial
    begin
        rxBitClock = 1'b0;
        serialIn = 1'b0;
        syncIn = 1'b0;
        txBitClock = 1'b1;
    end

    // both directions at one bit rate, 125 ns
    always
    begin
        #62 txBitClock = 1'b0;
        #63 txBitClock = 1'b1;
    end

    // mid-bit sample, the block shifts on the fall
    always @(posedge txBitClock)
        txSeen.push_back(serialOut);

    // clock stands still between frames; line flips so a stale bit is never reused
    task automatic send(input logic [7:0] d, input int n);
        for (int i = 0; i < n; i++)
        begin
            serialIn = d[i];
            #62 rxBitClock = 1'b1;
            #63 rxBitClock = 1'b0;
        end
        serialIn = ~serialIn;
    endtask

    // sync held high across n whole rx periods
    task automatic pulse_sync(input int n);
        syncIn = 1'b1;
        send(8'hFF, n);
        syncIn = 1'b0;
    endtask
endmodule

`default_nettype wire

// ### testbench/tb_usart_sync_hunt_standby.sv
`timescale 1ns/1ns
`default_nettype none

module tb_usart_sync_hunt_standby;
    import usart_pkg::*;
    localparam byte_t SYNC_A = 8'h16;
    localparam byte_t SYNC_B = 8'h69;
    logic       clock, nrst, controlSelect, wrStb, rdStb;
    byte_t      wrData, d, got;
    logic [7:0] rdData;
    logic       txBitClock, rxBitClock, serialIn, syncIn, serialOut, clearToSendN;
    logic       txBufferFree, txEmptyFlag, rxCharAvail, matchOrBreakOut;
    logic       terminalReadyOutN, requestToSendOutN;
    int         n_errors, n_compared, cycles, z;
    byte_t      rxExp[$];

    usart_sync_hunt_standby usart_sync_hunt_standby_i (.clock, .nrst, .clockEnable(1'b1),
        .controlSelect, .wrData, .wrStb, .rdStb, .rdData, .txBitClock, .rxBitClock,
        .serialIn, .syncIn, .clearToSendN, .serialOut, .txBufferFree, .txEmptyFlag,
        .rxCharAvail, .matchOrBreakOut, .terminalReadyOutN, .requestToSendOutN);
    remote_station remote_station_i (.rxBitClock, .serialIn, .syncIn, .txBitClock, .serialOut);

    initial
        clock = 1'b0;
    always #2 clock = ~clock;

    task automatic tally_and_finish();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // generous: whole run needs about 6k cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bchk(input logic g, input logic e);
        chk({7'h00, g}, {7'h00, e});
    endtask
    task automatic wr(input logic sel, input byte_t v);
        @(posedge clock);
        controlSelect <= sel;
        wrData <= v;
        wrStb <= 1'b1;
        @(posedge clock);
        wrStb <= 1'b0;
    endtask
    task automatic rd(input logic sel, output byte_t v);
        @(posedge clock);
        controlSelect <= sel;
        rdStb <= 1'b1;
        @(posedge clock);
        rdStb <= 1'b0;
        #1 v = rdData;
    endtask
    task automatic stat(input byte_t e);
        rd(1'b1, got);
        chk(got & 8'h40, e);
    endtask
    task automatic standby_pins();
        chk({1'b0, txBufferFree, txEmptyFlag, rxCharAvail, matchOrBreakOut, serialOut,
             terminalReadyOutN, requestToSendOutN}, 8'h07);
    endtask
    function automatic logic has_seq(input logic [23:0] p);
        bit s[$];
        s = remote_station_i.txSeen;
        for (int i = 0; i + 24 <= s.size(); i++)
        begin
            int k;
            k = 0;
            for (int j = 0; j < 24; j++)
                if (s[i + j] == p[j])
                    k++;
            if (k == 24)
                return 1'b1;
        end
        return 1'b0;
    endfunction

    initial
    begin
        nrst = 1'b0;
        controlSelect = 1'b0;
        wrStb = 1'b0;
        rdStb = 1'b0;
        wrData = 8'h00;
        clearToSendN = 1'b0;
        void'($urandom(28));
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        standby_pins();
        rd(1'b1, got);
        standby_pins();
        // two sync chars, 8 bits, internal sync
        wr(1'b1, 8'h0C);
        wr(1'b1, SYNC_A);
        wr(1'b1, SYNC_B);
        wr(1'b1, 8'h94);
        remote_station_i.send(8'($urandom), 4);
        remote_station_i.send(SYNC_A, 8);
        repeat (20) @(posedge clock);
        bchk(matchOrBreakOut, 1'b0);
        remote_station_i.send(SYNC_B, 8);
        repeat (20) @(posedge clock);
        bchk(matchOrBreakOut, 1'b1);
        stat(8'h40);
        stat(8'h00);
        do
            d = 8'($urandom);
        while (d == SYNC_A || d == SYNC_B);
        rxExp.push_back(d);
        remote_station_i.send(d, 8);
        repeat (20) @(posedge clock);
        bchk(rxCharAvail, 1'b1);
        bchk(matchOrBreakOut, 1'b0);
        rd(1'b0, got);
        chk(got, rxExp.pop_front());
        remote_station_i.send(SYNC_A, 8);
        repeat (20) @(posedge clock);
        bchk(matchOrBreakOut, 1'b1);
        wr(1'b1, 8'h27);
        remote_station_i.txSeen.delete();
        repeat (800) @(posedge clock);
        z = 0;
        foreach (remote_station_i.txSeen[i])
            if (remote_station_i.txSeen[i] == 1'b0)
                z++;
        chk(8'(z), 8'h00);
        chk({5'h00, txBufferFree, terminalReadyOutN, requestToSendOutN}, 8'h04);
        d = 8'($urandom);
        wr(1'b0, d);
        repeat (2000) @(posedge clock);
        bchk(txEmptyFlag, 1'b1);
        bchk(has_seq({SYNC_B, SYNC_A, d}), 1'b1);
        // clear to send high freezes the line mid-character
        clearToSendN <= 1'b1;
        repeat (40) @(posedge clock);
        got = {7'h00, serialOut};
        remote_station_i.txSeen.delete();
        repeat (400) @(posedge clock);
        bchk(txBufferFree, 1'b0);
        z = 0;
        foreach (remote_station_i.txSeen[i])
            if (remote_station_i.txSeen[i] != got[0])
                z++;
        chk(8'(z), 8'h00);
        clearToSendN <= 1'b0;
        // command only while a sync char shifts out
        wr(1'b0, SYNC_A);
        @(posedge clock iff txBufferFree);
        wr(1'b1, 8'h40);
        repeat (4) @(posedge clock);
        standby_pins();
        // external sync, single sync char
        wr(1'b1, 8'hCC);
        wr(1'b1, SYNC_A);
        wr(1'b1, 8'h94);
        repeat (4) @(posedge clock);
        bchk(matchOrBreakOut, 1'b0);
        remote_station_i.pulse_sync(3);
        repeat (20) @(posedge clock);
        bchk(matchOrBreakOut, 1'b1);
        stat(8'h40);
        stat(8'h00);
        remote_station_i.pulse_sync(3);
        repeat (20) @(posedge clock);
        stat(8'h40);
        // even parity, internal sync, one sync char
        wr(1'b1, 8'h40);
        wr(1'b1, 8'hBC);
        wr(1'b1, SYNC_A);
        wr(1'b1, 8'h94);
        remote_station_i.send(SYNC_A, 8);
        remote_station_i.send(8'h01, 1);
        repeat (20) @(posedge clock);
        stat(8'h40);
        // first char carries a bad parity bit and is then overrun
        for (int i = 0; i < 2; i++)
        begin
            do
                d = 8'($urandom);
            while (d == SYNC_A);
            rxExp.push_back(d);
            remote_station_i.send(d, 8);
            remote_station_i.send({7'h00, (^d) ^ (i == 0)}, 1);
        end
        repeat (20) @(posedge clock);
        rd(1'b1, got);
        chk(got & 8'h1A, 8'h1A);
        rd(1'b0, got);
        rxExp.delete(0);
        chk(got, rxExp.pop_front());
        // re-hunt with error clear zeroes errors; a bad parity bit during hunt goes unchecked
        wr(1'b1, 8'h94);
        remote_station_i.send(SYNC_A, 8);
        remote_station_i.send(8'h00, 1);
        repeat (20) @(posedge clock);
        rd(1'b1, got);
        chk(got & 8'h58, 8'h40);
        tally_and_finish();
    end
endmodule

`default_nettype wire
